//--- bench/hsc_board.sv
// board model: ejector handle switch and clock-control strap
`timescale 1ns/1ns
module hsc_board (
    // clock
    input wire logic core_clk,
    // scenario commands
    input wire logic handle_open_cmd,
    input wire logic strap_cmd,
    // pins toward the bridge
    output logic ejector_open,
    output logic bus_clock_control_strap
);
    // pins move on the rising edge of core_clk, by nonblocking update; one driver per pin
    always @(posedge core_clk) begin
        ejector_open <= handle_open_cmd;
        bus_clock_control_strap <= strap_cmd;
    end
endmodule : hsc_board

//--- bench/hsc_regs_tb.sv
// self-checking bench for the hot-swap register bank
`timescale 1ns/1ns
module hsc_regs_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic open_cmd = 1'b1;
    logic strap_cmd = 1'b0;
    logic ejector_open, strap, alert, led, sec_run, irq;
    int fail_count = 0;
    int samples_checked = 0;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    hsc_board board (.core_clk(core_clk), .handle_open_cmd(open_cmd),
        .strap_cmd(strap_cmd), .ejector_open(ejector_open),
        .bus_clock_control_strap(strap));

    hsc_regs DUT (.core_clk(core_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_clock_control_strap(strap), .ejector_open(ejector_open),
        .swap_alert_output(alert), .swap_indicator_led(led),
        .sec_clk_run(sec_run), .irq(irq));

    task automatic chk(input string name, input logic [7:0] exp,
            input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask : rd

    // two sync flops, flag, then registered output
    task automatic settle();
        repeat (5) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic pins(input logic a_exp, input logic l_exp);
        chk("alert", {7'h00, a_exp}, {7'h00, alert});
        chk("led", {7'h00, l_exp}, {7'h00, led});
    endtask : pins

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // watchdog, far beyond the roughly 160 cycles of the sequence
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        settle();
        rd(8'hE6, 8'h00);
        pins(1'b0, 1'b1);
        rd(8'hE2, 8'h00);
        rd(8'hE3, 8'h00);
        rd(8'hE4, 8'h06);
        rd(8'hE5, 8'h00);
        rd(8'hE7, 8'h00);
        wr(8'hE6, 8'hF5);
        rd(8'hE6, 8'h00);
        pins(1'b0, 1'b1);
        // close the handle: insertion, LED handed to software
        @(posedge core_clk);
        open_cmd <= 1'b0;
        settle();
        rd(8'hE6, 8'h80);
        pins(1'b1, 1'b0);
        wr(8'hE6, 8'h0A);
        settle();
        rd(8'hE6, 8'h8A);
        pins(1'b0, 1'b1);
        wr(8'hE6, 8'h82);
        rd(8'hE6, 8'h02);
        // open the handle with the alert still masked
        @(posedge core_clk);
        open_cmd <= 1'b1;
        settle();
        rd(8'hE6, 8'h42);
        pins(1'b0, 1'b0);
        wr(8'hE6, 8'h00);
        settle();
        rd(8'hE6, 8'h40);
        pins(1'b1, 1'b0);
        wr(8'hE6, 8'h40);
        settle();
        rd(8'hE6, 8'h00);
        pins(1'b0, 1'b0);
        // interrupt: raise, mask, clear; a 1 in the mask blocks its event
        rd(8'hE9, 8'h03);
        chk("irq", 8'h01, {7'h00, irq});
        wr(8'hEA, 8'h02);
        settle();
        chk("irq", 8'h01, {7'h00, irq});
        wr(8'hEA, 8'h03);
        settle();
        chk("irq", 8'h00, {7'h00, irq});
        wr(8'hE9, 8'h03);
        rd(8'hE9, 8'h00);
        wr(8'hEA, 8'h00);
        settle();
        chk("irq", 8'h00, {7'h00, irq});
        // secondary clocks: D3hot stops them only with strap high
        wr(8'hE8, 8'h03);
        settle();
        chk("sec_run", 8'h01, {7'h00, sec_run});
        @(posedge core_clk);
        strap_cmd <= 1'b1;
        settle();
        rd(8'hE2, 8'hC0);
        chk("sec_run", 8'h00, {7'h00, sec_run});
        wr(8'hE8, 8'h02);
        settle();
        chk("sec_run", 8'h01, {7'h00, sec_run});
        rd(8'hE8, 8'h02);
        wr(8'hE8, 8'h01);
        settle();
        chk("sec_run", 8'h01, {7'h00, sec_run});
        // second reset with the handle open, then close it again
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        settle();
        rd(8'hE6, 8'h00);
        pins(1'b0, 1'b1);
        chk("sec_run", 8'h01, {7'h00, sec_run});
        rd(8'hE9, 8'h00);
        @(posedge core_clk);
        open_cmd <= 1'b0;
        settle();
        rd(8'hE6, 8'h80);
        pins(1'b1, 1'b0);
        chk("irq", 8'h01, {7'h00, irq});
        conclude();
    end
endmodule : hsc_regs_tb

//--- inc/hsc_params.svh
// constants for the hot-swap capability register bank
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH
`define HSC_ADDR_W 8
`define HSC_OFF_BRIDGE 8'hE2
`define HSC_OFF_DATA 8'hE3
`define HSC_OFF_CAPID 8'hE4
`define HSC_OFF_LINK 8'hE5
`define HSC_OFF_CTRL 8'hE6
`define HSC_OFF_PSTATE 8'hE8
`define HSC_OFF_IRQ_STAT 8'hE9
`define HSC_OFF_IRQ_MASK 8'hEA
`define HSC_CAP_ID_VAL 8'h06
`define HSC_LINK_VAL 8'h00
`define HSC_DATA_VAL 8'h00
`define HSC_CTRL_RST 8'h00
`define HSC_CTRL_RSVD 8'h35
`define HSC_BRIDGE_RSVD 8'h3F
`define HSC_BIT_INS 7
`define HSC_BIT_EXT 6
`define HSC_BIT_LED 3
`define HSC_BIT_MASK 1
`define HSC_BIT_BCC 7
`define HSC_BIT_B2B3 6
`define HSC_IRQ_INS 0
`define HSC_IRQ_EXT 1
`define HSC_PS_D3HOT 2'h3
`endif

//--- inc/hsc_pkg.sv
// types for the hot-swap capability register bank
package hsc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hsc_req_t;
    typedef enum logic [2:0] {
        HSC_LED_FORCED = 3'h1,
        HSC_LED_SOFT = 3'h2,
        HSC_LED_IDLE = 3'h4
    } hsc_led_state_t;
endpackage : hsc_pkg

//--- logic/hsc_regs.sv
// hot-swap and bridge power support register bank
// Operation
// - bit 7 of bridge power support reads the clock-control strap
// - bit 6 reads strap too; 1 stops secondary clocks in D3hot
// - secondary clock gating derives from the strap and the D3hot power state, registered on the primary clock
// - bits 5..0 of bridge power support read zero
// - power data byte is unimplemented and reads zero
// - hot-swap capability identifier reads fixed 06h
// - hot-swap next-item pointer reads zero
// - insertion flag sets after reset, handle closed, extraction clear
// - extraction flag sets when handle opens and insertion is clear
// - alert output asserts while either status flag is set and the mask bit is clear
// - software writes never set insertion or extraction flags
// - after the reset period the LED bit drives the LED output; here only once the handle has closed after reset
// - after reset LED forced high until handle closes
// - mask bit 1 gates alert output; 1 masks it
// - status flags set regardless of the mask bit
// - reserved control bits 5, 4, 2, 0 read zero
// - control/status byte resets to all zeros
// - power state 11 is D3hot, where secondary clocks may stop
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "hsc_params.svh"
module hsc_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // board pins
    input wire logic bus_clock_control_strap,
    input wire logic ejector_open,
    output logic swap_alert_output,
    output logic swap_indicator_led,
    // secondary clock gating and interrupt
    output logic sec_clk_run,
    output logic irq
);
    hsc_pkg::hsc_req_t req;
    logic strap_s1_reg, strap_s2_reg, ej_s1_reg, ej_s2_reg, ej_prev_reg;
    logic ins_reg, ins_next, ext_reg, ext_next, led_bit_reg, mask_bit_reg;
    logic armed_reg, armed_next;
    logic [1:0] pstate_reg;
    logic [1:0] irq_stat_reg, irq_stat_next, irq_mask_reg;
    logic [7:0] rdata_next;
    logic alert_reg, led_reg, run_reg, irq_reg;
    hsc_pkg::hsc_led_state_t led_st_reg, led_st_next;

    // bundle the request
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic hit_wr(input hsc_pkg::hsc_req_t r,
                                    input logic [7:0] off);
        hit_wr = r.wr && (r.addr == off);
    endfunction : hit_wr

    // decode
    wire wr_ctrl = hit_wr(req, `HSC_OFF_CTRL);
    wire wr_ps = hit_wr(req, `HSC_OFF_PSTATE);
    wire wr_istat = hit_wr(req, `HSC_OFF_IRQ_STAT);
    wire wr_imask = hit_wr(req, `HSC_OFF_IRQ_MASK);
    wire clr_ins = wr_ctrl && req.wdata[`HSC_BIT_INS];
    wire clr_ext = wr_ctrl && req.wdata[`HSC_BIT_EXT];
    wire handle_closed = !ej_s2_reg;
    wire open_edge = ej_s2_reg && !ej_prev_reg;
    wire set_ins = armed_reg && handle_closed && !ext_reg;
    wire set_ext = open_edge && !ins_reg;
    wire [7:0] bridge_byte = {strap_s2_reg, strap_s2_reg, 6'h00};
    wire [7:0] ctrl_byte = {ins_reg, ext_reg, 2'h0, led_bit_reg, 1'b0,
                            mask_bit_reg, 1'b0};

    // pin synchronisers; strap is a pin too
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_s1_reg <= 1'b0;
            strap_s2_reg <= 1'b0;
            ej_s1_reg <= 1'b1;
            ej_s2_reg <= 1'b1;
            ej_prev_reg <= 1'b1;
        end else begin
            strap_s1_reg <= bus_clock_control_strap;
            strap_s2_reg <= strap_s1_reg;
            ej_s1_reg <= ejector_open;
            ej_s2_reg <= ej_s1_reg;
            ej_prev_reg <= ej_s2_reg;
        end
    end

    // status flags: hardware set beats software clear
    always_comb begin
        ins_next = (ins_reg && !clr_ins) || set_ins;
        ext_next = (ext_reg && !clr_ext) || set_ext;
        armed_next = armed_reg && !set_ins; // one insertion per reset
        irq_stat_next = irq_stat_reg & ~(wr_istat ? req.wdata[1:0] : 2'h0);
        irq_stat_next[`HSC_IRQ_INS] = irq_stat_next[`HSC_IRQ_INS] || set_ins;
        irq_stat_next[`HSC_IRQ_EXT] = irq_stat_next[`HSC_IRQ_EXT] || set_ext;
    end

    // led ownership after reset
    always_comb begin
        case (led_st_reg)
            hsc_pkg::HSC_LED_FORCED:
                led_st_next = handle_closed ? hsc_pkg::HSC_LED_SOFT
                                            : hsc_pkg::HSC_LED_FORCED;
            hsc_pkg::HSC_LED_SOFT: led_st_next = hsc_pkg::HSC_LED_SOFT;
            default: led_st_next = hsc_pkg::HSC_LED_FORCED;
        endcase
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_next = 8'h00;
        if (req.rd) begin
            case (req.addr)
                `HSC_OFF_BRIDGE: rdata_next = bridge_byte;
                `HSC_OFF_DATA: rdata_next = `HSC_DATA_VAL;
                `HSC_OFF_CAPID: rdata_next = `HSC_CAP_ID_VAL;
                `HSC_OFF_LINK: rdata_next = `HSC_LINK_VAL;
                `HSC_OFF_CTRL: rdata_next = ctrl_byte;
                `HSC_OFF_PSTATE: rdata_next = {6'h00, pstate_reg};
                `HSC_OFF_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
                `HSC_OFF_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // register state; control byte clears on reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ins_reg <= 1'b0;
            ext_reg <= 1'b0;
            led_bit_reg <= 1'b0;
            mask_bit_reg <= 1'b0;
            armed_reg <= 1'b1;
            pstate_reg <= 2'h0;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            led_st_reg <= hsc_pkg::HSC_LED_FORCED;
            reg_rdata <= 8'h00;
        end else begin
            ins_reg <= ins_next;
            ext_reg <= ext_next;
            armed_reg <= armed_next;
            irq_stat_reg <= irq_stat_next;
            led_st_reg <= led_st_next;
            reg_rdata <= rdata_next;
            if (wr_ctrl) begin
                led_bit_reg <= req.wdata[`HSC_BIT_LED];
                mask_bit_reg <= req.wdata[`HSC_BIT_MASK];
            end
            if (wr_ps)
                pstate_reg <= req.wdata[1:0];
            if (wr_imask)
                irq_mask_reg <= req.wdata[1:0];
        end
    end

    // registered outputs, one cycle behind the state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            alert_reg <= 1'b0;
            led_reg <= 1'b1;
            run_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            alert_reg <= (ins_reg || ext_reg) && !mask_bit_reg;
            led_reg <= (led_st_reg == hsc_pkg::HSC_LED_SOFT)
                       ? led_bit_reg : 1'b1;
            // gate only; the clocks themselves come from core_clk
            run_reg <= !(strap_s2_reg
                         && pstate_reg == `HSC_PS_D3HOT);
            irq_reg <= |(irq_stat_reg & ~irq_mask_reg); // 1 in mask blocks
        end
    end

    assign swap_alert_output = alert_reg;
    assign swap_indicator_led = led_reg;
    assign sec_clk_run = run_reg;
    assign irq = irq_reg;

    // assertions
    property p_alert;
        @(posedge core_clk) disable iff (!rst_b)
        ((ins_reg || ext_reg) && !mask_bit_reg) |=> swap_alert_output;
    endproperty
    a_alert: assert property (p_alert) else $error("alert missing");

    property p_mask;
        @(posedge core_clk) disable iff (!rst_b)
        mask_bit_reg |=> !swap_alert_output;
    endproperty
    a_mask: assert property (p_mask) else $error("alert not masked");

    property p_nosw_set;
        @(posedge core_clk) disable iff (!rst_b)
        (!ins_reg && !set_ins) |=> !ins_reg;
    endproperty
    a_nosw_set: assert property (p_nosw_set)
        else $error("insertion flag set without cause");

    property p_ext_set;
        @(posedge core_clk) disable iff (!rst_b)
        (open_edge && !ins_reg) |=> ext_reg;
    endproperty
    a_ext_set: assert property (p_ext_set)
        else $error("extraction flag not set");

    property p_ins_set;
        @(posedge core_clk) disable iff (!rst_b)
        (armed_reg && handle_closed && !ext_reg) |=> ins_reg;
    endproperty
    a_ins_set: assert property (p_ins_set)
        else $error("insertion flag not set");

    sequence s_forced;
        led_st_reg == hsc_pkg::HSC_LED_FORCED;
    endsequence
    property p_led_forced;
        @(posedge core_clk) disable iff (!rst_b)
        s_forced |=> swap_indicator_led;
    endproperty
    a_led_forced: assert property (p_led_forced)
        else $error("led not forced high");

    property p_led_soft;
        @(posedge core_clk) disable iff (!rst_b)
        (led_st_reg == hsc_pkg::HSC_LED_SOFT)
            |=> swap_indicator_led == $past(led_bit_reg);
    endproperty
    a_led_soft: assert property (p_led_soft)
        else $error("led does not follow bit");

    property p_rsvd;
        @(posedge core_clk) disable iff (!rst_b)
        (req.rd && req.addr == `HSC_OFF_CTRL)
            |=> (reg_rdata & `HSC_CTRL_RSVD) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits nonzero");

    property p_capid;
        @(posedge core_clk) disable iff (!rst_b)
        (req.rd && req.addr == `HSC_OFF_CAPID)
            |=> reg_rdata == `HSC_CAP_ID_VAL;
    endproperty
    a_capid: assert property (p_capid) else $error("bad cap id");

    property p_clk_stop;
        @(posedge core_clk) disable iff (!rst_b)
        (strap_s2_reg && pstate_reg == `HSC_PS_D3HOT) |=> !sec_clk_run;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("secondary clocks not stopped");

    // strap low: the secondary clocks never stop
    property p_run_on;
        @(posedge core_clk) disable iff (!rst_b)
        !strap_s2_reg |=> sec_clk_run;
    endproperty
    a_run_on: assert property (p_run_on)
        else $error("secondary clocks stopped with strap low");

    // bridge support byte seen on the data cycle of its read
    sequence s_rd_bridge;
        req.rd && req.addr == `HSC_OFF_BRIDGE;
    endsequence
    property p_bcc_bit;
        @(posedge core_clk) disable iff (!rst_b)
        s_rd_bridge |=> reg_rdata[`HSC_BIT_BCC] == $past(strap_s2_reg);
    endproperty
    a_bcc_bit: assert property (p_bcc_bit)
        else $error("clock-control bit does not follow strap");

    property p_b2b3_bit;
        @(posedge core_clk) disable iff (!rst_b)
        s_rd_bridge |=> reg_rdata[`HSC_BIT_B2B3] == $past(strap_s2_reg);
    endproperty
    a_b2b3_bit: assert property (p_b2b3_bit)
        else $error("clock-stop bit does not follow strap");

    property p_bridge_rsvd;
        @(posedge core_clk) disable iff (!rst_b)
        s_rd_bridge |=> (reg_rdata & `HSC_BRIDGE_RSVD) == 8'h00;
    endproperty
    a_bridge_rsvd: assert property (p_bridge_rsvd)
        else $error("bridge support low bits nonzero");

    // constant bytes; a wrong value here breaks capability list walks
    property p_data_zero;
        @(posedge core_clk) disable iff (!rst_b)
        (req.rd && req.addr == `HSC_OFF_DATA)
            |=> reg_rdata == `HSC_DATA_VAL;
    endproperty
    a_data_zero: assert property (p_data_zero)
        else $error("power data byte nonzero");

    property p_link_zero;
        @(posedge core_clk) disable iff (!rst_b)
        (req.rd && req.addr == `HSC_OFF_LINK)
            |=> reg_rdata == `HSC_LINK_VAL;
    endproperty
    a_link_zero: assert property (p_link_zero)
        else $error("next-item pointer nonzero");

    // extraction flag: no set without cause, set through the mask
    property p_nosw_ext;
        @(posedge core_clk) disable iff (!rst_b)
        (!ext_reg && !set_ext) |=> !ext_reg;
    endproperty
    a_nosw_ext: assert property (p_nosw_ext)
        else $error("extraction flag set without cause");

    property p_mask_free;
        @(posedge core_clk) disable iff (!rst_b)
        (set_ext && mask_bit_reg) |=> ext_reg;
    endproperty
    a_mask_free: assert property (p_mask_free)
        else $error("mask kept extraction flag clear");

    // write-one-clear, unless the hardware sets in the same cycle
    property p_clr_ins;
        @(posedge core_clk) disable iff (!rst_b)
        (ins_reg && clr_ins && !set_ins) |=> !ins_reg;
    endproperty
    a_clr_ins: assert property (p_clr_ins)
        else $error("insertion flag not cleared");

    property p_clr_ext;
        @(posedge core_clk) disable iff (!rst_b)
        (ext_reg && clr_ext && !set_ext) |=> !ext_reg;
    endproperty
    a_clr_ext: assert property (p_clr_ext)
        else $error("extraction flag not cleared");

    property p_release;
        @(posedge core_clk) disable iff (!rst_b)
        (!ins_reg && !ext_reg) |=> !swap_alert_output;
    endproperty
    a_release: assert property (p_release)
        else $error("alert held with both flags clear");

    // led stays forced while the handle is still open
    property p_led_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (led_st_reg == hsc_pkg::HSC_LED_FORCED && !handle_closed)
            |=> s_forced;
    endproperty
    a_led_hold: assert property (p_led_hold)
        else $error("led released before handle closed");

    // first edge out of reset sees the cleared control byte
    property p_rst_ctrl;
        @(posedge core_clk) disable iff (!rst_b)
        $rose(rst_b) |-> ctrl_byte == `HSC_CTRL_RST;
    endproperty
    a_rst_ctrl: assert property (p_rst_ctrl)
        else $error("control byte not clear after reset");
endmodule : hsc_regs
